// ---- logic/pao_pkg.sv ----
// Functional notes
// - Control bit 7 set runs the oscillator, cleared stops it.
// - Control bit 5 reads back the present output level.
// - Control bit 4 set inverts the output, cleared passes it unchanged.
// - Control bit 0 set selects pulse mode, output rate equals carry rate.
// - Control bit 0 clear selects square wave mode, half the carry rate.
// - Width field bits 7:5 gives active time of two to the code periods.
// - Width field applies only in pulse mode, ignored in square wave mode.
// - Source field bits 3:0 selects source clock; 1010 and 1111 reserved.
// - Running sum is 20 bits across three byte registers, upper bits reserved.
// - Sum bytes map upper 23:16, high 15:8, low 7:0.
// - Step value is 20-bit read/write, resets to one.
// - Step shadow loads all 20 bits on next source falling edge after low write.
// - Each source rising edge while running adds shadow step to sum; bit 19 carry is overflow.
// - Pulse mode output goes active on edge after overflow, inactive after width.
// - Each overflow sets a sticky flag until software clears it.
// - While disabled, step byte writes update the shadow at once.
package pao_pkg;
    localparam logic [11:0] PAO_SUM_LOW_ADDR   = 12'h58C;
    localparam logic [11:0] PAO_SUM_HIGH_ADDR  = 12'h58D;
    localparam logic [11:0] PAO_SUM_UPPER_ADDR = 12'h58E;
    localparam logic [11:0] PAO_STEP_LOW_ADDR  = 12'h58F;
    localparam logic [11:0] PAO_STEP_HIGH_ADDR = 12'h590;
    localparam logic [11:0] PAO_STEP_UPPER_ADDR = 12'h591;
    localparam logic [11:0] PAO_CONTROL_ADDR   = 12'h592;
    localparam logic [11:0] PAO_SELECT_ADDR    = 12'h593;
    localparam logic [11:0] PAO_FLAG_ADDR      = 12'h594;

    localparam int PAO_CTL_ENABLE_BIT = 7;
    localparam int PAO_CTL_OUT_BIT    = 5;
    localparam int PAO_CTL_INVERT_BIT = 4;
    localparam int PAO_CTL_PULSE_BIT  = 0;
    localparam int PAO_SEL_WIDTH_MSB  = 7;
    localparam int PAO_SEL_WIDTH_LSB  = 5;
    localparam int PAO_SEL_SRC_MSB    = 3;
    localparam int PAO_SEL_SRC_LSB    = 0;

    localparam logic [19:0] PAO_STEP_RESET = 20'h00001;
    localparam logic [3:0]  PAO_SRC_RSVD_A = 4'hA;
    localparam logic [3:0]  PAO_SRC_RSVD_B = 4'hF;

    typedef enum logic [1:0] {
        PAO_LOAD_IDLE = 2'b00,
        PAO_LOAD_WAIT = 2'b01
    } pao_load_t;
endpackage

// ---- logic/pao_src_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_src_select
    import pao_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Sources and select
    input  wire logic [15:0] i_sources,
    input  wire logic [3:0]  i_select,
    // Source edges
    output logic             o_rise,
    output logic             o_fall
);
    logic       level_reg;
    logic       sel_level;
    logic       sel_valid;

    // Reserved codes hold the source low, so no rising edges appear
    assign sel_valid = (i_select != PAO_SRC_RSVD_A) && (i_select != PAO_SRC_RSVD_B);
    assign sel_level = sel_valid & i_sources[i_select];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= sel_level;
        end
    end

    assign o_rise = sel_level & ~level_reg;
    assign o_fall = ~sel_level & level_reg;
endmodule
`default_nettype wire

// ---- logic/pao_width_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_width_timer
    import pao_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Control
    input  wire logic       i_tick,
    input  wire logic       i_start,
    input  wire logic [2:0] i_width_code,
    // Status
    output logic            o_active
);
    logic [7:0] count_reg;
    logic       active_reg;
    logic [7:0] periods;

    assign periods = 8'h01 << i_width_code;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_reg  <= 8'h00;
            active_reg <= 1'b0;
        end else if (i_tick) begin
            if (i_start) begin
                active_reg <= 1'b1;
                count_reg  <= periods - 8'h01;
            end else if (count_reg != 8'h00) begin
                count_reg <= count_reg - 8'h01;
            end else begin
                active_reg <= 1'b0;
            end
        end
    end

    assign o_active = active_reg;
endmodule
`default_nettype wire

// ---- logic/pao_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_top
    import pao_pkg::*;
#(
    parameter int SUM_WIDTH = 20
) (
    // Clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET,
    // Register port
    input  wire logic [11:0] I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [7:0]  O_RDATA,
    // Candidate source clocks, indexed by select code
    input  wire logic [15:0] I_SOURCES,
    // Oscillator output and events
    output logic             O_OSC_OUT,
    output logic             O_OVERFLOW_FLAG
);
    // Register state
    logic [7:0]           control_reg;
    logic [7:0]           select_reg;
    logic [SUM_WIDTH-1:0] sum_reg;
    logic [SUM_WIDTH-1:0] step_reg;
    logic [SUM_WIDTH-1:0] shadow_reg;
    logic                 flag_reg;
    logic                 level_reg;
    logic                 out_reg;
    logic [7:0]           rdata_reg;
    pao_load_t            load_reg;

    // Decoded controls
    logic                 enable;
    logic                 invert;
    logic                 pulse_mode;
    logic [2:0]           width_code;
    logic [3:0]           src_code;
    logic                 src_rise;
    logic                 src_fall;
    logic                 tick;
    logic [SUM_WIDTH:0]   sum_next;
    logic                 overflow;
    logic                 pulse_active;
    logic                 raw_level;
    logic                 out_next;
    logic [7:0]           rdata_next;
    logic [23:0]          sum_wide;
    logic [23:0]          step_wide;

    logic wr_sum_l;
    logic wr_sum_h;
    logic wr_sum_u;
    logic wr_step_l;
    logic wr_step_h;
    logic wr_step_u;
    logic wr_ctl;
    logic wr_sel;
    logic wr_flag;

    assign enable     = control_reg[PAO_CTL_ENABLE_BIT];
    assign invert     = control_reg[PAO_CTL_INVERT_BIT];
    assign pulse_mode = control_reg[PAO_CTL_PULSE_BIT];
    assign width_code = select_reg[PAO_SEL_WIDTH_MSB:PAO_SEL_WIDTH_LSB];
    assign src_code   = select_reg[PAO_SEL_SRC_MSB:PAO_SEL_SRC_LSB];

    assign wr_sum_l  = I_WR && (I_ADDR == PAO_SUM_LOW_ADDR);
    assign wr_sum_h  = I_WR && (I_ADDR == PAO_SUM_HIGH_ADDR);
    assign wr_sum_u  = I_WR && (I_ADDR == PAO_SUM_UPPER_ADDR);
    assign wr_step_l = I_WR && (I_ADDR == PAO_STEP_LOW_ADDR);
    assign wr_step_h = I_WR && (I_ADDR == PAO_STEP_HIGH_ADDR);
    assign wr_step_u = I_WR && (I_ADDR == PAO_STEP_UPPER_ADDR);
    assign wr_ctl    = I_WR && (I_ADDR == PAO_CONTROL_ADDR);
    assign wr_sel    = I_WR && (I_ADDR == PAO_SELECT_ADDR);
    assign wr_flag   = I_WR && (I_ADDR == PAO_FLAG_ADDR);

    pao_src_select u_src (
        .i_clk     (I_REF_CLK),
        .i_rst     (I_RESET),
        .i_sources (I_SOURCES),
        .i_select  (src_code),
        .o_rise    (src_rise),
        .o_fall    (src_fall)
    );

    assign tick     = enable & src_rise;
    assign sum_next = {1'b0, sum_reg} + {1'b0, shadow_reg};
    assign overflow = tick & sum_next[SUM_WIDTH];

    pao_width_timer u_width (
        .i_clk        (I_REF_CLK),
        .i_rst        (I_RESET),
        .i_tick       (tick),
        .i_start      (overflow & pulse_mode),
        .i_width_code (width_code),
        .o_active     (pulse_active)
    );

    // Pulse mode uses the width timer; width field ignored otherwise
    assign raw_level = pulse_mode ? pulse_active : level_reg;
    assign out_next  = raw_level ^ invert;

    // Square wave level toggles on each carry
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            level_reg <= 1'b0;
        end else if (overflow && !pulse_mode) begin
            level_reg <= ~level_reg;
        end
    end

    // Running sum; software writes while running are undefined by contract
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            sum_reg <= '0;
        end else if (tick) begin
            sum_reg <= sum_next[SUM_WIDTH-1:0];
        end else if (wr_sum_l) begin
            sum_reg[7:0] <= I_WDATA;
        end else if (wr_sum_h) begin
            sum_reg[15:8] <= I_WDATA;
        end else if (wr_sum_u) begin
            sum_reg[SUM_WIDTH-1:16] <= I_WDATA[SUM_WIDTH-17:0];
        end
    end

    // Step bytes, reset to one
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            step_reg <= PAO_STEP_RESET;
        end else if (wr_step_l) begin
            step_reg[7:0] <= I_WDATA;
        end else if (wr_step_h) begin
            step_reg[15:8] <= I_WDATA;
        end else if (wr_step_u) begin
            step_reg[SUM_WIDTH-1:16] <= I_WDATA[SUM_WIDTH-17:0];
        end
    end

    // Shadow: immediate when stopped, else armed by low byte until source fall
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            shadow_reg <= PAO_STEP_RESET;
            load_reg   <= PAO_LOAD_IDLE;
        end else if (!enable) begin
            shadow_reg <= step_reg;
            load_reg   <= PAO_LOAD_IDLE;
        end else begin
            case (load_reg)
                PAO_LOAD_IDLE: begin
                    // Upper and high bytes assumed already written
                    if (wr_step_l) begin
                        load_reg <= PAO_LOAD_WAIT;
                    end
                end
                PAO_LOAD_WAIT: begin
                    if (src_fall) begin
                        shadow_reg <= step_reg;
                        load_reg   <= wr_step_l ? PAO_LOAD_WAIT : PAO_LOAD_IDLE;
                    end
                end
                default: begin
                    load_reg <= PAO_LOAD_IDLE;
                end
            endcase
        end
    end

    // Control, select, flag; set wins over clear
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            control_reg <= 8'h00;
            select_reg  <= 8'h00;
            flag_reg    <= 1'b0;
            out_reg     <= 1'b0;
        end else begin
            if (wr_ctl) begin
                control_reg <= I_WDATA & 8'h91;
            end
            if (wr_sel) begin
                select_reg <= I_WDATA;
            end
            if (overflow) begin
                flag_reg <= 1'b1;
            end else if (wr_flag && !I_WDATA[0]) begin
                flag_reg <= 1'b0;
            end
            out_reg <= out_next;
        end
    end

    assign sum_wide  = {{(24-SUM_WIDTH){1'b0}}, sum_reg};
    assign step_wide = {{(24-SUM_WIDTH){1'b0}}, step_reg};

    always_comb begin
        case (I_ADDR)
            PAO_SUM_LOW_ADDR:    rdata_next = sum_wide[7:0];
            PAO_SUM_HIGH_ADDR:   rdata_next = sum_wide[15:8];
            PAO_SUM_UPPER_ADDR:  rdata_next = sum_wide[23:16];
            PAO_STEP_LOW_ADDR:   rdata_next = step_wide[7:0];
            PAO_STEP_HIGH_ADDR:  rdata_next = step_wide[15:8];
            PAO_STEP_UPPER_ADDR: rdata_next = step_wide[23:16];
            PAO_CONTROL_ADDR:    rdata_next = control_reg | {2'b00, out_reg, 5'b00000};
            PAO_SELECT_ADDR:     rdata_next = select_reg;
            PAO_FLAG_ADDR:       rdata_next = {7'b0000000, flag_reg};
            default:             rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            rdata_reg <= 8'h00;
        end else if (I_RD) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign O_RDATA         = rdata_reg;
    assign O_OSC_OUT       = out_reg;
    assign O_OVERFLOW_FLAG = flag_reg;
endmodule
`default_nettype wire

// ---- dv/pao_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_chk
    import pao_pkg::*;
#(
    parameter int SUM_WIDTH = 20
) (
    // Clock, reset, register port
    input wire logic        I_REF_CLK,
    input wire logic        I_RESET,
    input wire logic [11:0] I_ADDR,
    input wire logic [7:0]  I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [7:0]  O_RDATA,
    // Sources and outputs
    input wire logic [15:0] I_SOURCES,
    input wire logic        O_OSC_OUT,
    input wire logic        O_OVERFLOW_FLAG
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    wire rd_ctl = I_RD && I_ADDR == PAO_CONTROL_ADDR;
    wire unmapped = I_ADDR < PAO_SUM_LOW_ADDR || I_ADDR > PAO_FLAG_ADDR;
    rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    reset_clear_a: assert property ($past(I_RESET) |-> !O_OSC_OUT && !O_OVERFLOW_FLAG)
        else $error("outputs not cleared by reset");
    flag_hold_a: assert property ($past(O_OVERFLOW_FLAG) && !$past(I_RESET) && !$past(I_WR) |-> O_OVERFLOW_FLAG)
        else $error("flag dropped without clear");
    flag_cause_a: assert property ($rose(O_OVERFLOW_FLAG) && !$past(I_WR) |-> $past(I_SOURCES) != $past(I_SOURCES, 2))
        else $error("flag set without source edge");
    out_bit_a: assert property (rd_ctl |=> O_RDATA[5] == O_OSC_OUT || O_RDATA[5] == $past(O_OSC_OUT))
        else $error("control bit 5 not output level");
    ctl_rsvd_a: assert property (rd_ctl |=> O_RDATA[6] == 1'b0 && O_RDATA[3:1] == 3'h0)
        else $error("control unused bits set");
    upper_rsvd_a: assert property (I_RD && (I_ADDR == PAO_SUM_UPPER_ADDR || I_ADDR == PAO_STEP_UPPER_ADDR)
        |=> O_RDATA[7:4] == 4'h0)
        else $error("upper byte unused bits set");
    unmapped_rd_a: assert property (I_RD && unmapped |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    sel_back_a: assert property (I_WR && I_ADDR == PAO_SELECT_ADDR ##2 I_RD && I_ADDR == PAO_SELECT_ADDR
        |=> O_RDATA == $past(I_WDATA, 3))
        else $error("select readback differs");
endmodule
bind pao_top pao_chk #(.SUM_WIDTH(SUM_WIDTH)) u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SOURCES(I_SOURCES),
    .O_OSC_OUT(O_OSC_OUT), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG));
`default_nettype wire

// ---- dv/pao_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_sink (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Oscillator level as a peripheral sees it
    input wire logic i_level,
    // Rising edges seen and length of last high phase
    output var int   o_rises,
    output var int   o_high_len
);
    logic prev_reg;
    int   run_reg;
    always_ff @(posedge i_clk) begin
        prev_reg <= i_level;
        run_reg <= i_level ? run_reg + 1 : 0;
        if (i_rst) begin
            o_rises <= 0;
            o_high_len <= 0;
        end else begin
            if (i_level && !prev_reg) o_rises <= o_rises + 1;
            if (!i_level && prev_reg) o_high_len <= run_reg;
        end
    end
endmodule
`default_nettype wire

// ---- dv/pao_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pao_top_tb
    import pao_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] src = 16'h0000;
    logic        src_run = 1'b0;
    logic [2:0]  div = 3'h0;
    wire logic [7:0] rdata;
    wire logic   osc;
    wire logic   flag;
    int          rises;
    int          high_len;
    int          n_mismatch = 0;
    int          n_checks = 0;
    always #5 clk = ~clk;
    // Every source toggles every 8 cycles: one tick per 16 cycles
    always @(posedge clk) begin
        div <= div + 3'h1;
        if (src_run && div == 3'h7) src <= ~src;
    end
    pao_top DUT (.I_REF_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_SOURCES(src), .O_OSC_OUT(osc), .O_OVERFLOW_FLAG(flag));
    pao_sink u_sink (.i_clk(clk), .i_rst(rst), .i_level(osc), .o_rises(rises), .o_high_len(high_len));
    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic wait_rises(input int n);
        int lim;
        lim = 0;
        while (rises < n && lim < 4000) begin
            @(posedge clk);
            lim++;
        end
        if (lim >= 4000) begin
            n_mismatch++;
            close_out();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(PAO_STEP_LOW_ADDR, 8'h01);
        rd_chk(PAO_STEP_HIGH_ADDR, 8'h00);
        rd_chk(PAO_CONTROL_ADDR, 8'h00);
        wr_reg(12'h595, 8'hFF);
        rd_chk(12'h595, 8'h00);
        wr_reg(PAO_SELECT_ADDR, 8'hEA);
        rd_chk(PAO_SELECT_ADDR, 8'hEA);
        wr_reg(PAO_CONTROL_ADDR, 8'h6E);
        rd_chk(PAO_CONTROL_ADDR, 8'h00);
        wr_reg(PAO_SUM_HIGH_ADDR, 8'h3C);
        rd_chk(PAO_SUM_HIGH_ADDR, 8'h3C);
        wr_reg(PAO_STEP_UPPER_ADDR, 8'hF8);
        wr_reg(PAO_STEP_HIGH_ADDR, 8'h00);
        wr_reg(PAO_STEP_LOW_ADDR, 8'h00);
        rd_chk(PAO_STEP_UPPER_ADDR, 8'h08);
        // Reserved source code must stay silent
        src_run <= 1'b1;
        wr_reg(PAO_CONTROL_ADDR, 8'h80);
        repeat (200) @(posedge clk);
        `CHK(flag, 1'b0)
        wr_reg(PAO_SELECT_ADDR, 8'hE0);
        wait_rises(2);
        `CHK(high_len, 32)
        `CHK(flag, 1'b1)
        wr_reg(PAO_STEP_UPPER_ADDR, 8'h01);
        wr_reg(PAO_STEP_HIGH_ADDR, 8'h00);
        wr_reg(PAO_STEP_LOW_ADDR, 8'h00);
        wr_reg(PAO_CONTROL_ADDR, 8'h81);
        for (int i = 0; i < 4; i++) begin
            wr_reg(PAO_SELECT_ADDR, {i[2:0], 5'h00});
            // First pulse after a change may be merged, judge the second
            wait_rises(rises + 3);
            `CHK(high_len, 16 << i)
        end
        wr_reg(PAO_SELECT_ADDR, 8'h00);
        wr_reg(PAO_CONTROL_ADDR, 8'h91);
        wait_rises(rises + 2);
        repeat (20) @(posedge clk);
        `CHK(osc, 1'b1)
        rd_chk(PAO_CONTROL_ADDR, 8'hB1);
        wr_reg(PAO_CONTROL_ADDR, 8'h00);
        wr_reg(PAO_FLAG_ADDR, 8'h00);
        repeat (200) @(posedge clk);
        `CHK(flag, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
